// ### design/ctc_map.svh
// Register map, field positions, widths and reset values of the capture trigger controller.
// Overview of operation
// - Free run ignores every trigger input and acquires from start until stop.
// - External source fires when its selected input reaches or passes the level.
// - Mask source fires whenever the spectrum violates the selected frequency mask.
// - Power threshold source fires when time-domain power reaches or passes the threshold.
// - Signed offset: positive delays measurement start, negative reaches before event.
// - All sources but the mask and free run honour a rising or falling slope setting.
// - Holdoff sets a minimum spacing; events inside it are discarded.
// - Holdoff is effective only in mark-only mode.
// - Data from a programmable pretrigger interval before each event is retained.
// - Capture continues for a programmable posttrigger interval after each event.
// - Auto-rearm starts a measurement per event and rearms at once.
// - Stop-on-trigger halts after one sweep and keeps its pre and post data.
// - Early events are accepted and give a shortened pretrigger segment.
// - Mark-only acquires as free run and just tags events in the results.
// - Any source but free run raises the active indicator and reports the source.
`ifndef CTC_MAP_SVH
`define CTC_MAP_SVH

`define CTC_ADDR_W      5
`define CTC_SMP_W       16
`define CTC_CNT_W       16
`define CTC_PRE_W       17

`define CTC_CTRL_OFS    5'h00
`define CTC_LEVEL_OFS   5'h04
`define CTC_OFFSET_OFS  5'h08
`define CTC_HOLDOFF_OFS 5'h0C
`define CTC_PRE_OFS     5'h10
`define CTC_POST_OFS    5'h14
`define CTC_STATUS_OFS  5'h18

`define CTC_CTRL_SRC_LSB   0
`define CTC_CTRL_SLOPE_BIT 3
`define CTC_CTRL_MODE_LSB  4
`define CTC_CTRL_START_BIT 8
`define CTC_CTRL_STOP_BIT  9

`define CTC_ST_CAPTURE_BIT 0
`define CTC_ST_ARMED_BIT   1
`define CTC_ST_ACTIVE_BIT  2
`define CTC_ST_SRC_LSB     4
`define CTC_ST_HALTED_BIT  8
`define CTC_ST_SHORT_BIT   9

`define CTC_LEVEL_RST   16'h0000
`define CTC_CNT_RST     16'h0000

`endif

// ### design/ctc_pkg.sv
// Types shared by the capture trigger controller.
package ctc_pkg;

	typedef enum logic [2:0] {
		free_run_source_code,
		external_input_one_code,
		external_input_two_code,
		external_input_three_code,
		mask_source_code,
		power_threshold_source_code
	} ctc_src_e;

	typedef enum logic [1:0] {
		auto_rearm,
		stop_on_trigger,
		mark_only
	} ctc_mode_e;

	typedef enum logic [2:0] {
		st_idle,
		st_run,
		st_armed,
		st_delay,
		st_post
	} ctc_fsm_e;

endpackage : ctc_pkg

// ### design/ctc_trigger.sv
// Capture trigger controller with its Avalon-MM register slave.
`include "ctc_map.svh"

module ctc_trigger (
	input  wire logic                         mclk,              // 250 MHz clock.
	input  wire logic                         rst_n,             // Async reset, active low.
	input  wire logic [`CTC_ADDR_W-1:0]       avs_address,       // Byte address.
	input  wire logic                         avs_read,          // Read request.
	input  wire logic                         avs_write,         // Write request.
	input  wire logic [31:0]                  avs_writedata,     // Write data.
	input  wire logic [3:0]                   avs_byteenable,    // Byte lanes.
	output logic [31:0]                       avs_readdata,      // Read data.
	output logic                              avs_waitrequest,   // Stall.
	input  wire logic [`CTC_SMP_W-1:0]        ext_in_1,          // External input 1 sample.
	input  wire logic [`CTC_SMP_W-1:0]        ext_in_2,          // External input 2 sample.
	input  wire logic [`CTC_SMP_W-1:0]        ext_in_3,          // External input 3 sample.
	input  wire logic [`CTC_SMP_W-1:0]        power_in,          // Time-domain power.
	input  wire logic                         mask_violation,    // Mask checker result.
	output logic                              capture_en,        // Acquisition running.
	output logic                              trigger_mark,      // Tag pulse, mark-only.
	output logic                              frame_start,       // Trigger accepted pulse.
	output logic                              frame_done,        // Posttrigger end pulse.
	output logic [`CTC_PRE_W-1:0]             pre_keep,          // Pretrigger samples kept.
	output logic                              trigger_active_indicator, // Source not free run.
	output ctc_pkg::ctc_src_e                 source_report      // Selected source.
);

	typedef struct packed {
		logic                      wait_q;
		logic [31:0]               rdata;
		ctc_pkg::ctc_src_e         src;
		logic                      falling;
		ctc_pkg::ctc_mode_e        mode;
		logic [`CTC_SMP_W-1:0]     level;
		logic [`CTC_CNT_W-1:0]     offset;
		logic [`CTC_CNT_W-1:0]     holdoff;
		logic [`CTC_CNT_W-1:0]     pre_len;
		logic [`CTC_CNT_W-1:0]     post_len;
		ctc_pkg::ctc_fsm_e         fsm;
		logic [`CTC_CNT_W-1:0]     cnt;
		logic [`CTC_PRE_W-1:0]     pre_cnt;
		logic [`CTC_CNT_W-1:0]     hold_cnt;
		logic                      cond_prev;
		logic                      capture;
		logic                      mark;
		logic                      fstart;
		logic                      fdone;
		logic [`CTC_PRE_W-1:0]     keep;
		logic                      halted;
		logic                      pre_short;
		logic                      active;
		ctc_pkg::ctc_src_e         src_rep;
	} ctc_state_s;

	ctc_state_s r;
	ctc_state_s next_r;

	// Level condition for one source honouring the slope direction.
	function automatic logic over_level(input logic [`CTC_SMP_W-1:0] x,
			input logic [`CTC_SMP_W-1:0] lvl, input logic fall);
		over_level = fall ? (x <= lvl) : (x >= lvl);
	endfunction : over_level

	// Merge a write into a register honouring byte enables.
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
			input logic [3:0] be);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				res[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		merge = res;
	endfunction : merge

	logic                      req;
	logic                      take;
	logic                      cond;
	logic                      event_hit;
	logic                      start_cmd;
	logic                      stop_cmd;
	logic [31:0]               ctrl_new;
	logic [31:0]               ctrl_word;
	logic [31:0]               status_word;
	logic [`CTC_PRE_W-1:0]     pre_target;
	logic [`CTC_CNT_W-1:0]     neg_off;

	// Current source condition and its rising edge as the trigger event.
	always_comb begin
		case (r.src)
			ctc_pkg::external_input_one_code: begin
				cond = over_level(ext_in_1, r.level, r.falling);
			end
			ctc_pkg::external_input_two_code: begin
				cond = over_level(ext_in_2, r.level, r.falling);
			end
			ctc_pkg::external_input_three_code: begin
				cond = over_level(ext_in_3, r.level, r.falling);
			end
			ctc_pkg::power_threshold_source_code: begin
				cond = over_level(power_in, r.level, r.falling);
			end
			ctc_pkg::mask_source_code: begin
				cond = mask_violation;
			end
			default: begin
				cond = 1'b0;
			end
		endcase
		event_hit = cond && !r.cond_prev;
	end

	// Bus decode: a request is served on the cycle waitrequest is low.
	assign req  = avs_read || avs_write;
	assign take = req && !r.wait_q;
	assign ctrl_word = {22'h000000, 4'h0, 2'(r.mode), r.falling, 3'(r.src)};
	assign ctrl_new  = merge(ctrl_word, avs_writedata, avs_byteenable);
	assign start_cmd = take && avs_write && (avs_address == `CTC_CTRL_OFS)
		&& ctrl_new[`CTC_CTRL_START_BIT];
	assign stop_cmd  = take && avs_write && (avs_address == `CTC_CTRL_OFS)
		&& ctrl_new[`CTC_CTRL_STOP_BIT];
	assign neg_off    = r.offset[`CTC_CNT_W-1] ? (~r.offset + 16'h0001) : 16'h0000;
	assign pre_target = {1'b0, r.pre_len} + {1'b0, neg_off};

	// Status word built from live controller state.
	always_comb begin
		status_word = 32'h00000000;
		status_word[`CTC_ST_CAPTURE_BIT] = r.capture;
		status_word[`CTC_ST_ARMED_BIT]   = (r.fsm == ctc_pkg::st_armed);
		status_word[`CTC_ST_ACTIVE_BIT]  = r.active;
		status_word[`CTC_ST_SRC_LSB +: 3] = 3'(r.src);
		status_word[`CTC_ST_HALTED_BIT]  = r.halted;
		status_word[`CTC_ST_SHORT_BIT]   = r.pre_short;
	end

	// Next-state logic for the bus slave, configuration and trigger sequencer.
	always_comb begin
		next_r        = r;
		next_r.mark   = 1'b0;
		next_r.fstart = 1'b0;
		next_r.fdone  = 1'b0;
		next_r.cond_prev = cond;
		next_r.wait_q = !(req && r.wait_q);
		if (req && r.wait_q) begin
			case (avs_address)
				`CTC_CTRL_OFS:    next_r.rdata = ctrl_word;
				`CTC_LEVEL_OFS:   next_r.rdata = {16'h0000, r.level};
				`CTC_OFFSET_OFS:  next_r.rdata = {16'h0000, r.offset};
				`CTC_HOLDOFF_OFS: next_r.rdata = {16'h0000, r.holdoff};
				`CTC_PRE_OFS:     next_r.rdata = {16'h0000, r.pre_len};
				`CTC_POST_OFS:    next_r.rdata = {16'h0000, r.post_len};
				`CTC_STATUS_OFS:  next_r.rdata = status_word;
				default:          next_r.rdata = 32'h00000000;
			endcase
		end
		if (take && avs_write) begin
			case (avs_address)
				`CTC_CTRL_OFS: begin
					next_r.src     = ctc_pkg::ctc_src_e'(ctrl_new[`CTC_CTRL_SRC_LSB +: 3]);
					next_r.falling = ctrl_new[`CTC_CTRL_SLOPE_BIT];
					next_r.mode    = ctc_pkg::ctc_mode_e'(ctrl_new[`CTC_CTRL_MODE_LSB +: 2]);
				end
				`CTC_LEVEL_OFS:   next_r.level    = 16'(merge({16'h0000, r.level}, avs_writedata,
					avs_byteenable));
				`CTC_OFFSET_OFS:  next_r.offset   = 16'(merge({16'h0000, r.offset}, avs_writedata,
					avs_byteenable));
				`CTC_HOLDOFF_OFS: next_r.holdoff  = 16'(merge({16'h0000, r.holdoff}, avs_writedata,
					avs_byteenable));
				`CTC_PRE_OFS:     next_r.pre_len  = 16'(merge({16'h0000, r.pre_len}, avs_writedata,
					avs_byteenable));
				`CTC_POST_OFS:    next_r.post_len = 16'(merge({16'h0000, r.post_len}, avs_writedata,
					avs_byteenable));
				default: begin
				end
			endcase
		end
		next_r.active  = (next_r.src != ctc_pkg::free_run_source_code);
		next_r.src_rep = next_r.src;
		if (r.hold_cnt != 16'h0000) begin
			next_r.hold_cnt = r.hold_cnt - 16'h0001;
		end
		case (r.fsm)
			ctc_pkg::st_run: begin
				// Free run and mark-only capture without a break.
				next_r.capture = 1'b1;
				if (r.mode == ctc_pkg::mark_only && event_hit && r.hold_cnt == 16'h0000) begin
					next_r.mark     = 1'b1;
					next_r.hold_cnt = r.holdoff;
				end
			end
			ctc_pkg::st_armed: begin
				next_r.capture = 1'b1;
				if (r.pre_cnt < pre_target) begin
					next_r.pre_cnt = r.pre_cnt + 17'h00001;
				end
				if (event_hit) begin
					next_r.fstart    = 1'b1;
					next_r.keep      = r.pre_cnt;
					next_r.pre_short = (r.pre_cnt < pre_target);
					if (!r.offset[`CTC_CNT_W-1] && r.offset != 16'h0000) begin
						next_r.fsm = ctc_pkg::st_delay;
						next_r.cnt = r.offset;
					end else begin
						next_r.fsm = ctc_pkg::st_post;
						next_r.cnt = r.post_len;
					end
				end
			end
			ctc_pkg::st_delay: begin
				next_r.cnt = r.cnt - 16'h0001;
				if (r.cnt == 16'h0001) begin
					next_r.fsm = ctc_pkg::st_post;
					next_r.cnt = r.post_len;
				end
			end
			ctc_pkg::st_post: begin
				if (r.cnt != 16'h0000) begin
					next_r.cnt = r.cnt - 16'h0001;
				end else begin
					next_r.fdone   = 1'b1;
					next_r.pre_cnt = 17'h00000;
					if (r.mode == ctc_pkg::stop_on_trigger) begin
						next_r.fsm     = ctc_pkg::st_idle;
						next_r.capture = 1'b0;
						next_r.halted  = 1'b1;
					end else begin
						next_r.fsm = ctc_pkg::st_armed;
					end
				end
			end
			default: begin
				next_r.capture = 1'b0;
			end
		endcase
		// Start rearms from any state; stop wins over start.
		if (start_cmd) begin
			next_r.halted   = 1'b0;
			next_r.pre_cnt  = 17'h00000;
			next_r.hold_cnt = 16'h0000;
			next_r.capture  = 1'b1;
			if (next_r.src == ctc_pkg::free_run_source_code
					|| next_r.mode == ctc_pkg::mark_only) begin
				next_r.fsm = ctc_pkg::st_run;
			end else begin
				next_r.fsm = ctc_pkg::st_armed;
			end
		end
		if (stop_cmd) begin
			next_r.fsm     = ctc_pkg::st_idle;
			next_r.capture = 1'b0;
		end
	end

	// State register with constant reset values.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			r           <= '0;
			r.wait_q    <= 1'b1;
			r.src       <= ctc_pkg::free_run_source_code;
			r.mode      <= ctc_pkg::auto_rearm;
			r.fsm       <= ctc_pkg::st_idle;
			r.src_rep   <= ctc_pkg::free_run_source_code;
			r.level     <= `CTC_LEVEL_RST;
			r.offset    <= `CTC_CNT_RST;
		end else begin
			r <= next_r;
		end
	end

	// Outputs straight from the state flops.
	assign avs_readdata             = r.rdata;
	assign avs_waitrequest          = r.wait_q;
	assign capture_en               = r.capture;
	assign trigger_mark             = r.mark;
	assign frame_start              = r.fstart;
	assign frame_done               = r.fdone;
	assign pre_keep                 = r.keep;
	assign trigger_active_indicator = r.active;
	assign source_report            = r.src_rep;

endmodule : ctc_trigger

// ### dv/ctc_src_model.sv
// Model of the trigger lines, the power signal and the mask checker.
module ctc_src_model (
	input  wire logic [2:0] sel,            // Line that carries the event.
	input  wire logic       mclk,           // Clock.
	input  wire logic       fire,           // Event level requested.
	input  wire logic       inv,            // Inverts the event level of the three lines and power.
	output logic      [15:0] ext_in_1,      // Line one.
	output logic      [15:0] ext_in_2,      // Line two.
	output logic      [15:0] ext_in_3,      // Line three.
	output logic      [15:0] power_in,      // Power sample.
	output logic             mask_violation // Mask result.
);
	timeunit 1ns;
	timeprecision 1ps;

	// Only the chosen line moves; the others rest low.
	function automatic logic [15:0] lv(input logic hit);
		return (hit && (fire ^ inv)) ? 16'h0800 : 16'h0010;
	endfunction : lv

	// Samples change one clock after the request, as a real source would.
	always_ff @(posedge mclk) begin
		ext_in_1       <= lv(sel == 3'h1);
		ext_in_2       <= lv(sel == 3'h2);
		ext_in_3       <= lv(sel == 3'h3);
		mask_violation <= (sel == 3'h4) && fire;
		power_in       <= lv(sel == 3'h5);
	end
endmodule : ctc_src_model

// ### dv/ctc_trigger_properties.sv
// Concurrent checks on the ports of the capture trigger controller.
`include "ctc_map.svh"
module ctc_trigger_properties (
	input wire logic                  mclk,                     // Clock.
	input wire logic                  rst_n,                    // Reset, active low.
	input wire logic                  avs_write,                // Write request.
	input wire logic                  capture_en,               // Acquisition on.
	input wire logic                  trigger_mark,             // Tag pulse.
	input wire logic                  frame_start,              // Accept pulse.
	input wire logic                  frame_done,               // End pulse.
	input wire logic [`CTC_PRE_W-1:0] pre_keep,                 // Pretrigger kept.
	input wire logic                  trigger_active_indicator, // Source not free run.
	input wire ctc_pkg::ctc_src_e     source_report             // Selected source.
);
	timeunit 1ns;
	timeprecision 1ps;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	// Each property ties an output pulse or level to its cause.
	chk_active_src: assert property (trigger_active_indicator ==
		(source_report != ctc_pkg::free_run_source_code)) else $error("Active flag wrong.");
	chk_start_runs: assert property (frame_start |-> capture_en)
		else $error("Frame start while stopped.");
	chk_start_gap: assert property (frame_start |=> !frame_start [*2])
		else $error("Frame start inside post window.");
	chk_done_follows: assert property (frame_done |-> $past(capture_en))
		else $error("Frame done without capture.");
	chk_mark_free: assert property (trigger_mark |-> capture_en && !frame_start)
		else $error("Mark changed acquisition.");
	chk_mark_gap: assert property (trigger_mark |=> !trigger_mark)
		else $error("Marks too close.");
	chk_free_quiet: assert property (
		source_report == ctc_pkg::free_run_source_code |-> !frame_start && !trigger_mark)
		else $error("Free run fired.");
	chk_halt_holds: assert property ($rose(capture_en) |->
		$past(avs_write) || $past(avs_write, 2)) else $error("Capture began unasked.");
	chk_pre_hold: assert property (!$stable(pre_keep) |-> frame_start || trigger_mark)
		else $error("Pretrigger count moved.");
endmodule : ctc_trigger_properties

bind ctc_trigger ctc_trigger_properties ctc_trigger_properties_inst (
	.mclk(mclk), .rst_n(rst_n), .avs_write(avs_write), .capture_en(capture_en),
	.trigger_mark(trigger_mark), .frame_start(frame_start), .frame_done(frame_done),
	.pre_keep(pre_keep), .trigger_active_indicator(trigger_active_indicator),
	.source_report(source_report));

// ### dv/tb_top.sv
// Self-checking bench for the capture trigger controller.
`include "ctc_map.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk, rst_n, avs_read, avs_write, avs_waitrequest, mask_violation, fire, inv;
	logic capture_en, trigger_mark, frame_start, frame_done, trigger_active_indicator;
	logic [4:0]            avs_address;
	logic [31:0]           avs_writedata, avs_readdata, q;
	logic [3:0]            avs_byteenable;
	logic [15:0]           ext_in_1, ext_in_2, ext_in_3, power_in;
	logic [`CTC_PRE_W-1:0] pre_keep;
	logic [2:0]            sel;
	ctc_pkg::ctc_src_e     source_report;
	int                    err_total = 0, compares = 0, starts = 0, marks = 0, n, m0;

	ctc_trigger ctc_trigger_inst (.mclk(mclk), .rst_n(rst_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .ext_in_1(ext_in_1), .ext_in_2(ext_in_2),
		.ext_in_3(ext_in_3), .power_in(power_in), .mask_violation(mask_violation),
		.capture_en(capture_en), .trigger_mark(trigger_mark), .frame_start(frame_start),
		.frame_done(frame_done), .pre_keep(pre_keep), .source_report(source_report),
		.trigger_active_indicator(trigger_active_indicator));
	ctc_src_model ctc_src_model_inst (.mclk(mclk), .sel(sel), .fire(fire), .inv(inv),
		.ext_in_1(ext_in_1), .ext_in_2(ext_in_2), .ext_in_3(ext_in_3),
		.power_in(power_in), .mask_violation(mask_violation));

	// Clock and event counters.
	always #2 mclk = ~mclk;
	always @(posedge mclk) begin
		if (frame_start === 1'b1) starts <= starts + 1;
		if (trigger_mark === 1'b1) marks <= marks + 1;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// One bus access, held until waitrequest is sampled low.
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
			input logic [3:0] be);
		int k;
		k = 0;
		avs_address    <= a;
		avs_writedata  <= d;
		avs_byteenable <= be;
		avs_write      <= wr;
		avs_read       <= !wr;
		do begin
			@(posedge mclk);
			k++;
		end while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		chk(k, 2);
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
		@(posedge mclk);
	endtask : bus

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 4'hF);
	endtask : wr

	task automatic rd(input logic [4:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0, 4'hF);
		chk(q, exp);
	endtask : rd

	// Waits for a start or done pulse; n holds the cycles spent.
	task automatic wait_ev(input logic done);
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while ((done ? frame_done : frame_start) !== 1'b1 && n < 300);
		chk(n < 300, 1);
	endtask : wait_ev

	function automatic logic [31:0] ctl(input logic [2:0] s, input logic sl, input logic [1:0] m);
		return {22'h0, 2'h1, 2'h0, m, sl, s};
	endfunction : ctl

	task automatic final_report;
		$display("Comparisons %0d, mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : final_report

	// Hang guard.
	initial begin
		#40000;
		err_total++;
		final_report();
	end

	initial begin
		mclk = 1'b0;
		rst_n = 1'b0;
		{avs_read, avs_write, fire, inv} = 4'h0;
		avs_address = 5'h00;
		avs_writedata = 32'h0;
		avs_byteenable = 4'h0;
		sel = 3'h0;
		repeat (5) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		chk(avs_waitrequest, 1);
		rd(`CTC_STATUS_OFS, 32'h0);
		rd(5'h1C, 32'h0);
		bus(1'b1, `CTC_PRE_OFS, 32'hFFFF, 4'h1);
		rd(`CTC_PRE_OFS, 32'h00FF);
		wr(`CTC_STATUS_OFS, 32'hFFFF);
		rd(`CTC_STATUS_OFS, 32'h0);
		wr(`CTC_LEVEL_OFS, 32'h0100);
		wr(`CTC_PRE_OFS, 32'h8);
		wr(`CTC_POST_OFS, 32'h1);
		wr(`CTC_HOLDOFF_OFS, 32'd30);
		// Free run with an active line that must be ignored.
		sel <= 3'h1;
		fire <= 1'b1;
		wr(`CTC_CTRL_OFS, ctl(3'h0, 1'b0, 2'h0));
		m0 = starts;
		repeat (20) @(posedge mclk);
		chk(starts - m0, 0);
		chk(capture_en, 1);
		chk(trigger_active_indicator, 0);
		wr(`CTC_CTRL_OFS, 32'h200);
		@(posedge mclk);
		chk(capture_en, 0);
		// Every triggered source in stop mode; line three on the falling slope.
		for (int s = 1; s < 6; s++) begin
			sel <= 3'(s);
			inv <= (s == 3);
			fire <= 1'b0;
			wr(`CTC_CTRL_OFS, ctl(3'(s), s == 3, 2'h1));
			repeat (12) @(posedge mclk);
			fire <= 1'b1;
			wait_ev(1'b0);
			chk(pre_keep, 32'h8);
			wait_ev(1'b1);
			repeat (2) @(posedge mclk);
			chk(capture_en, 0);
			chk(source_report, s);
			chk(trigger_active_indicator, 1);
			rd(`CTC_STATUS_OFS, 32'h104 | (s << 4));
		end
		fire <= 1'b0;
		repeat (3) @(posedge mclk);
		fire <= 1'b1;
		repeat (6) @(posedge mclk);
		chk(capture_en, 0);
		// Auto rearm, then an early event inside the pretrigger span.
		sel <= 3'h1;
		inv <= 1'b0;
		fire <= 1'b0;
		wr(`CTC_CTRL_OFS, ctl(3'h1, 1'b0, 2'h0));
		repeat (12) @(posedge mclk);
		fire <= 1'b1;
		wait_ev(1'b0);
		fire <= 1'b0;
		wait_ev(1'b1);
		chk(n, 2);
		fire <= 1'b1;
		wait_ev(1'b0);
		chk(pre_keep < 17'h8, 1);
		chk(capture_en, 1);
		fire <= 1'b0;
		wait_ev(1'b1);
		rd(`CTC_STATUS_OFS, 32'h217);
		// Positive then negative offset.
		wr(`CTC_OFFSET_OFS, 32'd10);
		repeat (12) @(posedge mclk);
		fire <= 1'b1;
		wait_ev(1'b0);
		wait_ev(1'b1);
		chk(n >= 12 && n <= 13, 1);
		fire <= 1'b0;
		wr(`CTC_OFFSET_OFS, 32'hFFFC);
		repeat (20) @(posedge mclk);
		fire <= 1'b1;
		wait_ev(1'b0);
		chk(pre_keep, 32'hC);
		wait_ev(1'b1);
		// Mark only: four pulses, two fall inside the holdoff span.
		wr(`CTC_CTRL_OFS, 32'h200);
		wr(`CTC_OFFSET_OFS, 32'h0);
		fire <= 1'b0;
		wr(`CTC_CTRL_OFS, ctl(3'h1, 1'b0, 2'h2));
		m0 = marks;
		n = starts;
		for (int i = 0; i < 4; i++) begin
			fire <= 1'b1;
			repeat (4) @(posedge mclk);
			fire <= 1'b0;
			repeat ((i == 1) ? 40 : 4) @(posedge mclk);
		end
		chk(marks - m0, 2);
		chk(starts - n, 0);
		chk(capture_en, 1);
		final_report();
	end
endmodule : tb_top
